// file: verilog/hou_pkg.sv
package hou_pkg;
  // ****************************************************************
  // Register map (Wishbone byte addresses)
  // ****************************************************************
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_CONFIG = 8'h08;
  localparam logic [7:0] REG_IMG_LO = 8'h0C;
  localparam logic [7:0] REG_IMG_HI = 8'h10;
  localparam int CTRL_LOCK_BIT = 0;
  localparam int CTRL_HOLD_BIT = 1;
  localparam logic [1:0] CTRL_RESET = 2'h0;
  // ****************************************************************
  // Switch bank layout: bank one bits 0..3, bank two bits 4..7
  // ****************************************************************
  localparam int SW_IDLE_A = 0;
  localparam int SW_IDLE_B = 1;
  localparam int SW_BAUD = 2;
  localparam int SW_CFG_SRC = 3;
  localparam int SW_ADDR_MSB = 4;
  // ****************************************************************
  // Key indices: keys 1..16 at 0..15, keys 21..24 at 16..19
  // ****************************************************************
  localparam int KEY_TRAVERSE = 0;
  localparam int KEY_UPPER_RIGHT = 1;
  localparam int KEY_AUTO = 5;
  localparam int KEY_PLUS = 17;
  localparam int KEY_MINUS = 19;
  // ****************************************************************
  // Menu parameters, defaults and ranges
  // ****************************************************************
  localparam logic [4:0] CIRCLE_DEF = 5'h02;
  localparam logic [4:0] CIRCLE_MIN = 5'h01;
  localparam logic [4:0] CIRCLE_MAX = 5'h10;
  localparam logic [4:0] ADDR_DEF = 5'h0F;
  localparam logic [4:0] ADDR_MAX = 5'h1F;
  localparam logic BAUD_DEF_FAST = 1'b1;
  localparam logic [3:0] RX_GID = 4'h1;
  localparam logic [3:0] RX_OBJ = 4'h1;
  localparam logic [3:0] TX_CIRCLE = 4'h2;
  localparam logic [3:0] TX_GID = 4'h2;
  localparam logic [3:0] TX_OBJ = 4'h1;
  localparam logic [23:0] VER_NEWER = 24'h04_0101;
  localparam logic [23:0] VER_DEF = 24'h00_0001; // Arbitrary value
  // ****************************************************************
  // Override switch code per position 1..12
  // ****************************************************************
  localparam logic [4:0] OVR_CODE [12] = '{5'h01, 5'h04, 5'h0C, 5'h0D, 5'h0F, 5'h0E,
                                          5'h0A, 5'h0B, 5'h08, 5'h19, 5'h1A, 5'h1F};
  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int CLK_KHZ = 100_000;
  localparam int ALT_TIME_MS = 1000;
  localparam int ALT_CYCLES_DEF = ALT_TIME_MS * CLK_KHZ;
  typedef enum logic [1:0] {P_CIRCLE, P_BAUD, P_ADDR} hou_param_t;
  typedef enum logic [1:0] {ST_LOAD, ST_WAIT, ST_MENU, ST_RUN} hou_state_t;
endpackage

// file: verilog/hou_setup.sv
`timescale 1ns/10ps
module hou_setup #(
  parameter int ALT_CYCLES = hou_pkg::ALT_CYCLES_DEF,
  parameter logic [23:0] FW_VERSION = hou_pkg::VER_DEF
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic [7:0] dip_i,
  input wire logic [19:0] key_i,
  input wire logic [4:0] override_code_bits_i,
  input wire logic keyswitch_i,
  input wire logic disp_ack_i,
  input wire logic first_global_data_i,
  input wire logic [31:0] addr_used_i,
  input wire logic flash_valid_i,
  input wire logic [4:0] flash_circle_i,
  input wire logic flash_baud_i,
  input wire logic [4:0] flash_addr_i,
  output logic flash_wr_o,
  output logic [1:0] flash_sel_o,
  output logic [4:0] flash_data_o,
  output logic baud_fast_o,
  output logic [4:0] bus_addr_o,
  output logic idle_100ms_o,
  output logic [4:0] rx_circle_o,
  output logic disp_wait_o,
  output logic disp_page_o,
  output logic disp_menu_o,
  output logic [1:0] disp_param_o,
  output logic [4:0] disp_value_o,
  output logic disp_star_o,
  output logic [47:0] image_o
);
  import hou_pkg::*;

  localparam int CW = $clog2(ALT_CYCLES + 1);

  // ****************************************************************
  // Helpers
  // ****************************************************************
  // Position of an override code, zero when it is not in the table
  function automatic logic [3:0] ovr_pos(input logic [4:0] code);
    logic [3:0] p;
    p = 4'h0;
    for (int i = 0; i < 12; i++) begin
      if (OVR_CODE[i] == code) begin
        p = 4'(i + 1);
      end
    end
    return p;
  endfunction

  // Clamped step of a menu value
  function automatic logic [4:0] step(input logic [4:0] v, input logic up,
                                      input logic [4:0] lo, input logic [4:0] hi);
    logic [4:0] r;
    r = v;
    if (up && v < hi) begin
      r = v + 5'h01;
    end else if (!up && v > lo) begin
      r = v - 5'h01;
    end
    return r;
  endfunction

  // ****************************************************************
  // Pin synchronisers
  // ****************************************************************
  logic [34:0] sy1_ff, sy2_ff, nxt_sy1, nxt_sy2;
  logic [19:0] key_prev_ff, nxt_key_prev;
  // Pins come from switches and buttons, so both stages are plain flops
  always_comb begin
    nxt_sy1 = {disp_ack_i, keyswitch_i, override_code_bits_i, key_i, dip_i};
    nxt_sy2 = sy1_ff;
    nxt_key_prev = sy2_ff[27:8];
  end
  always_ff @(posedge clk_i) begin
    sy1_ff <= nxt_sy1;
    sy2_ff <= nxt_sy2;
    key_prev_ff <= nxt_key_prev;
  end

  logic [7:0] dip;
  logic [19:0] keys, key_rise;
  logic [4:0] ovr;
  logic ksw, dack;
  assign dip = sy2_ff[7:0];
  assign keys = sy2_ff[27:8];
  assign ovr = sy2_ff[32:28];
  assign ksw = sy2_ff[33];
  assign dack = sy2_ff[34];
  assign key_rise = keys & ~key_prev_ff;

  // ****************************************************************
  // Menu and start-up sequencing
  // ****************************************************************
  hou_state_t state_ff, nxt_state;
  hou_param_t param_ff, nxt_param;
  logic [4:0] circle_ff, nxt_circle, maddr_ff, nxt_maddr;
  logic mbaud_ff, nxt_mbaud, lock_ff, hold_ff, nxt_lock, nxt_hold;
  logic fwr_ff, nxt_fwr;
  logic [1:0] fsel_ff, nxt_fsel;
  logic [4:0] fdat_ff, nxt_fdat;
  logic chord;
  assign chord = keys[KEY_TRAVERSE] && keys[KEY_UPPER_RIGHT];

  // Chord is a held level; plus/minus/automatic act on their rising edge
  always_comb begin
    nxt_state = state_ff;
    nxt_param = param_ff;
    nxt_circle = circle_ff;
    nxt_maddr = maddr_ff;
    nxt_mbaud = mbaud_ff;
    nxt_fwr = 1'b0;
    nxt_fsel = fsel_ff;
    nxt_fdat = fdat_ff;
    case (state_ff)
      ST_LOAD: begin
        if (flash_valid_i && flash_circle_i >= CIRCLE_MIN && flash_circle_i <= CIRCLE_MAX) begin
          nxt_circle = flash_circle_i;
          nxt_mbaud = flash_baud_i;
          nxt_maddr = flash_addr_i;
        end
        nxt_state = ST_WAIT;
      end
      ST_WAIT: begin
        if (first_global_data_i) begin
          nxt_state = ST_RUN;
        end else if (chord && !lock_ff) begin
          nxt_state = ST_MENU;
          nxt_param = P_CIRCLE;
        end
      end
      ST_MENU: begin
        if (key_rise[KEY_AUTO]) begin
          nxt_fwr = 1'b1;
          nxt_fsel = param_ff;
          case (param_ff)
            P_CIRCLE: nxt_fdat = circle_ff;
            P_BAUD: nxt_fdat = {4'h0, mbaud_ff};
            default: nxt_fdat = maddr_ff;
          endcase
          if (param_ff == P_ADDR) begin
            nxt_state = ST_WAIT;
          end else begin
            nxt_param = hou_param_t'(param_ff + 2'h1);
          end
        end else if (key_rise[KEY_PLUS] ^ key_rise[KEY_MINUS]) begin
          case (param_ff)
            P_CIRCLE: nxt_circle = step(circle_ff, key_rise[KEY_PLUS],
                                        CIRCLE_MIN, CIRCLE_MAX);
            P_BAUD: nxt_mbaud = ~mbaud_ff;
            default: nxt_maddr = step(maddr_ff, key_rise[KEY_PLUS],
                                      5'h00, ADDR_MAX);
          endcase
        end
      end
      ST_RUN: nxt_state = ST_RUN;
      default: nxt_state = ST_WAIT;
    endcase
  end
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_ff <= ST_LOAD;
      param_ff <= P_CIRCLE;
      circle_ff <= CIRCLE_DEF;
      maddr_ff <= ADDR_DEF;
      mbaud_ff <= BAUD_DEF_FAST;
      fwr_ff <= 1'b0;
      fsel_ff <= 2'h0;
      fdat_ff <= 5'h00;
    end else begin
      state_ff <= nxt_state;
      param_ff <= nxt_param;
      circle_ff <= nxt_circle;
      maddr_ff <= nxt_maddr;
      mbaud_ff <= nxt_mbaud;
      fwr_ff <= nxt_fwr;
      fsel_ff <= nxt_fsel;
      fdat_ff <= nxt_fdat;
    end
  end

  // ****************************************************************
  // Bus parameter selection
  // ****************************************************************
  logic use_menu, baud_sel, idle_sel;
  logic [4:0] addr_sel;
  // Older firmware has no menu source, so it always follows the switches
  always_comb begin
    use_menu = dip[SW_CFG_SRC] && (FW_VERSION >= VER_NEWER);
    baud_sel = use_menu ? mbaud_ff : dip[SW_BAUD];
    addr_sel = use_menu ? maddr_ff
             : {1'b0, dip[SW_ADDR_MSB], dip[SW_ADDR_MSB + 1],
                dip[SW_ADDR_MSB + 2], dip[SW_ADDR_MSB + 3]};
    idle_sel = !use_menu && !dip[SW_IDLE_A] && dip[SW_IDLE_B];
  end

  // ****************************************************************
  // Display control and alternation timer
  // ****************************************************************
  logic [CW-1:0] alt_cnt_ff, nxt_alt_cnt;
  logic page_ff, nxt_page;
  always_comb begin
    nxt_alt_cnt = alt_cnt_ff;
    nxt_page = page_ff;
    if (state_ff != ST_WAIT || hold_ff) begin
      nxt_alt_cnt = '0;
    end else if (alt_cnt_ff == CW'(ALT_CYCLES - 1)) begin
      nxt_alt_cnt = '0;
      nxt_page = ~page_ff;
    end else begin
      nxt_alt_cnt = alt_cnt_ff + CW'(1);
    end
  end
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      alt_cnt_ff <= '0;
      page_ff <= 1'b0;
    end else begin
      alt_cnt_ff <= nxt_alt_cnt;
      page_ff <= nxt_page;
    end
  end

  // ****************************************************************
  // Registered outputs and input image
  // ****************************************************************
  logic [47:0] nxt_image;
  logic [4:0] nxt_dval;
  always_comb begin
    nxt_image = {dack, ksw, 1'b0, ovr, keys[19:16], 4'h0, keys[15:8], keys[7:0],
                 16'h0000};
    case (param_ff)
      P_CIRCLE: nxt_dval = circle_ff;
      P_BAUD: nxt_dval = {4'h0, mbaud_ff};
      default: nxt_dval = maddr_ff;
    endcase
  end
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      baud_fast_o <= 1'b0;
      bus_addr_o <= 5'h00;
      idle_100ms_o <= 1'b0;
      rx_circle_o <= CIRCLE_DEF;
      disp_wait_o <= 1'b1;
      disp_page_o <= 1'b0;
      disp_menu_o <= 1'b0;
      disp_param_o <= 2'h0;
      disp_value_o <= 5'h00;
      disp_star_o <= 1'b0;
      image_o <= '0;
      flash_wr_o <= 1'b0;
      flash_sel_o <= 2'h0;
      flash_data_o <= 5'h00;
    end else begin
      baud_fast_o <= baud_sel;
      bus_addr_o <= addr_sel;
      idle_100ms_o <= idle_sel;
      rx_circle_o <= circle_ff;
      disp_wait_o <= (state_ff != ST_RUN);
      disp_page_o <= page_ff;
      disp_menu_o <= (state_ff == ST_MENU);
      disp_param_o <= param_ff;
      disp_value_o <= nxt_dval;
      disp_star_o <= (state_ff == ST_MENU) && (param_ff == P_ADDR)
                     && addr_used_i[maddr_ff];
      image_o <= nxt_image;
      flash_wr_o <= fwr_ff;
      flash_sel_o <= fsel_ff;
      flash_data_o <= fdat_ff;
    end
  end

  // ****************************************************************
  // Wishbone classic slave, one wait state
  // ****************************************************************
  logic nxt_ack, wr_en;
  logic [31:0] nxt_dat;
  assign wr_en = wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o;
  // Unmapped addresses answer with ack and read zero
  always_comb begin
    nxt_ack = wb_cyc_i && wb_stb_i && !wb_ack_o;
    nxt_lock = lock_ff;
    nxt_hold = hold_ff;
    if (wr_en && wb_adr_i == REG_CTRL && wb_sel_i[0]) begin
      nxt_lock = wb_dat_i[CTRL_LOCK_BIT];
      nxt_hold = wb_dat_i[CTRL_HOLD_BIT];
    end
    case (wb_adr_i)
      REG_CTRL: nxt_dat = {30'h0, hold_ff, lock_ff};
      REG_STATUS: nxt_dat = {FW_VERSION, ovr_pos(ovr), use_menu, state_ff == ST_MENU,
                             state_ff == ST_RUN, state_ff == ST_WAIT};
      REG_CONFIG: nxt_dat = {TX_OBJ, TX_GID, TX_CIRCLE, RX_OBJ, RX_GID,
                             circle_ff, baud_sel, idle_sel, addr_sel};
      REG_IMG_LO: nxt_dat = image_o[31:0];
      REG_IMG_HI: nxt_dat = {16'h0000, image_o[47:32]};
      default: nxt_dat = 32'h0000_0000;
    endcase
  end
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
      lock_ff <= CTRL_RESET[CTRL_LOCK_BIT];
      hold_ff <= CTRL_RESET[CTRL_HOLD_BIT];
    end else begin
      wb_ack_o <= nxt_ack;
      wb_dat_o <= nxt_dat;
      lock_ff <= nxt_lock;
      hold_ff <= nxt_hold;
    end
  end

  // ****************************************************************
  // Assertions
  // ****************************************************************
  sequence s_enter_menu;
    state_ff == ST_WAIT && !first_global_data_i && chord && !lock_ff;
  endsequence
  sequence s_auto_store;
    state_ff == ST_MENU && key_rise[KEY_AUTO];
  endsequence

  a_menu_entry_gate: assert property (@(posedge clk_i) disable iff (rst_i)
    $rose(state_ff == ST_MENU) |-> $past(state_ff) == ST_WAIT && $past(chord))
    else $error("Menu entered without waiting state and key chord");
  a_menu_entry_time: assert property (@(posedge clk_i) disable iff (rst_i)
    s_enter_menu |=> state_ff == ST_MENU ##1 disp_menu_o)
    else $error("Key chord did not open the menu");
  a_auto_flash_wr: assert property (@(posedge clk_i) disable iff (rst_i)
    s_auto_store |=> ##1 flash_wr_o && flash_sel_o == $past(param_ff, 2))
    else $error("Automatic key did not store the parameter");
  a_circle_range: assert property (@(posedge clk_i) disable iff (rst_i)
    state_ff != ST_LOAD |-> rx_circle_o >= CIRCLE_MIN && rx_circle_o <= CIRCLE_MAX)
    else $error("Receive circle out of range");
  a_idle_decode: assert property (@(posedge clk_i) disable iff (rst_i)
    (!dip[SW_CFG_SRC] && !dip[SW_IDLE_A] && dip[SW_IDLE_B]) |=> idle_100ms_o)
    else $error("Idle time not selected by switches");
  a_switch_addr: assert property (@(posedge clk_i) disable iff (rst_i)
    !dip[SW_CFG_SRC] |=> bus_addr_o == {1'b0, $past(dip[4]), $past(dip[5]),
                                         $past(dip[6]), $past(dip[7])})
    else $error("Switch address decode wrong");
  a_wait_display: assert property (@(posedge clk_i) disable iff (rst_i)
    state_ff == ST_RUN |=> !disp_wait_o [*3])
    else $error("Waiting shown after PLC communication");
  a_image_layout: assert property (@(posedge clk_i) disable iff (rst_i)
    1'b1 |-> ##3 image_o[15:0] == 16'h0000 && image_o[35:32] == 4'h0
             && image_o[23:16] == $past(key_i[7:0], 3))
    else $error("Input image layout wrong");
  a_image_ack_bit: assert property (@(posedge clk_i) disable iff (rst_i)
    1'b1 |-> ##3 image_o[47] == $past(disp_ack_i, 3) && image_o[45] == 1'b0)
    else $error("Display acknowledge not in bit seven");
  a_wb_ack_pulse: assert property (@(posedge clk_i) disable iff (rst_i)
    wb_ack_o |=> !wb_ack_o)
    else $error("Bus acknowledge held longer than one cycle");
endmodule // hou_setup

// file: verification/hou_plc_model.sv
`timescale 1ns/10ps
// ****
// Controller on the far side of the bus
// ****
module hou_plc_model #(
  parameter logic [31:0] USED_MAP = 32'h0000_8004
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic send_i,
  output logic first_global_data_o,
  output logic [31:0] addr_used_o
);
  logic [3:0] dly_ff;
  // Nodes already present on the bus
  assign addr_used_o = USED_MAP;
  // First telegram leaves a few cycles after the command and stays seen
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dly_ff <= 4'h0;
      first_global_data_o <= 1'b0;
    end else begin
      if (send_i && dly_ff != 4'hF) dly_ff <= dly_ff + 4'h1;
      if (dly_ff == 4'h3) first_global_data_o <= 1'b1;
    end
  end
endmodule // hou_plc_model

// file: verification/test_hou_setup.sv
`timescale 1ns/10ps
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin err_total++; \
  $display("[ERR] t=%0t got=%h exp=%h", $time, (g), (e)); end end
module test_hou_setup;
  import hou_pkg::*;
  localparam int ALT_N = 8;
  localparam logic [19:0] KEYS = 20'hB_3C5A;
  localparam logic [7:0] DIP_SET [5] = '{8'h00, 8'hF6, 8'h16, 8'h81, 8'h25};
  localparam logic [4:0] OVR_TBL [12] = '{5'h01, 5'h04, 5'h0C, 5'h0D, 5'h0F, 5'h0E,
                                         5'h0A, 5'h0B, 5'h08, 5'h19, 5'h1A, 5'h1F};
  logic clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, keyswitch_i, disp_ack_i;
  logic first_global_data_i, flash_valid_i, flash_baud_i, flash_wr_o, baud_fast_o, idle_100ms_o;
  logic disp_wait_o, disp_page_o, disp_menu_o, disp_star_o, send;
  logic [7:0] wb_adr_i, dip_i;
  logic [3:0] wb_sel_i;
  logic [31:0] wb_dat_i, wb_dat_o, addr_used_i, rd;
  logic [19:0] key_i;
  logic [4:0] override_code_bits_i, flash_circle_i, flash_addr_i, flash_data_o;
  logic [4:0] bus_addr_o, rx_circle_o, disp_value_o;
  logic [1:0] flash_sel_o, disp_param_o;
  logic [47:0] image_o;
  int err_total = 0;
  int num_checks = 0;

  hou_setup #(.ALT_CYCLES(ALT_N), .FW_VERSION(VER_NEWER)) uut (.*);
  hou_plc_model #(.USED_MAP(32'h0000_8004)) plc (.clk_i(clk_i), .rst_i(rst_i),
    .send_i(send), .first_global_data_o(first_global_data_i), .addr_used_o(addr_used_i));

  // Free-running system clock
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end

  // ****
  // Shared helpers
  // ****
  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
  endtask

  task automatic close_out();
    $display("checks=%0d errors=%0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // Classic single cycle; request held until ack is seen
  task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] dat);
    int i;
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_sel_i <= 4'hF;
    wb_adr_i <= adr;
    wb_dat_i <= dat;
    for (i = 0; i < 20; i++) begin
      @(posedge clk_i);
      if (wb_ack_o === 1'b1) break;
    end
    if (i == 20) begin
      err_total++;
      close_out();
    end
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask

  // Long enough to clear the synchronisers and edge detect
  task automatic press(input int k);
    key_i[k] <= 1'b1;
    tick(6);
    key_i[k] <= 1'b0;
    tick(6);
  endtask

  task automatic chord(input logic menu);
    key_i[1:0] <= 2'b11;
    tick(8);
    `CHK(disp_menu_o, menu)
    key_i[1:0] <= 2'b00;
    tick(6);
  endtask

  task automatic auto_step(input logic [1:0] s, input logic [4:0] d);
    int i;
    key_i[KEY_AUTO] <= 1'b1;
    for (i = 0; i < 20; i++) begin
      @(posedge clk_i);
      if (flash_wr_o === 1'b1) break;
    end
    `CHK(i < 20, 1'b1)
    `CHK(flash_sel_o, s)
    `CHK(flash_data_o, d)
    key_i[KEY_AUTO] <= 1'b0;
    tick(6);
  endtask

  task automatic do_reset();
    rst_i <= 1'b1;
    send <= 1'b0;
    tick(8);
    rst_i <= 1'b0;
    tick(4);
  endtask

  // ****
  // Scenarios
  // ****
  task automatic t_reset();
    `CHK(disp_wait_o, 1'b1)
    `CHK(rx_circle_o, CIRCLE_DEF)
    `CHK(bus_addr_o, ADDR_DEF)
    `CHK(baud_fast_o, BAUD_DEF_FAST)
    `CHK(idle_100ms_o, 1'b0)
    wb(1'b0, REG_STATUS, 32'h0000_0000);
    `CHK(rd[0], 1'b1)
    `CHK(rd[31:8], VER_NEWER)
    wb(1'b0, 8'h40, 32'h0000_0000);
    `CHK(rd, 32'h0000_0000)
    wb(1'b1, REG_CTRL, 32'h0000_0003);
    wb(1'b0, REG_CTRL, 32'h0000_0000);
    `CHK(rd[1:0], 2'h3)
    wb(1'b1, REG_CTRL, 32'h0000_0000);
  endtask

  task automatic t_alt();
    logic p;
    int i;
    p = disp_page_o;
    for (i = 0; i < 3 * ALT_N; i++) begin
      @(posedge clk_i);
      if (disp_page_o !== p) break;
    end
    `CHK(disp_page_o !== p, 1'b1)
    wb(1'b1, REG_CTRL, 32'h0000_0002);
    tick(2);
    p = disp_page_o;
    tick(3 * ALT_N);
    `CHK(disp_page_o, p)
    wb(1'b1, REG_CTRL, 32'h0000_0000);
  endtask

  // Switch source: address MSB is the first address switch
  task automatic t_switches();
    logic [7:0] d;
    for (int i = 0; i < 5; i++) begin
      d = DIP_SET[i];
      dip_i <= d;
      tick(5);
      `CHK(bus_addr_o, {1'b0, d[4], d[5], d[6], d[7]})
      `CHK(baud_fast_o, d[2])
      `CHK(idle_100ms_o, ~d[0] & d[1])
    end
  endtask

  task automatic t_menu();
    wb(1'b1, REG_CTRL, 32'h0000_0001);
    chord(1'b0);
    wb(1'b1, REG_CTRL, 32'h0000_0000);
    chord(1'b1);
    `CHK(disp_param_o, P_CIRCLE)
    `CHK(disp_value_o, CIRCLE_DEF)
    repeat (2) press(KEY_MINUS);
    `CHK(disp_value_o, CIRCLE_MIN)
    repeat (16) press(KEY_PLUS);
    `CHK(disp_value_o, CIRCLE_MAX)
    auto_step(2'h0, CIRCLE_MAX);
    `CHK(disp_param_o, P_BAUD)
    `CHK(disp_value_o, 5'h01)
    press(KEY_PLUS);
    `CHK(disp_value_o, 5'h00)
    auto_step(2'h1, 5'h00);
    `CHK(disp_value_o, ADDR_DEF)
    `CHK(disp_star_o, 1'b1)
    press(KEY_PLUS);
    `CHK(disp_star_o, 1'b0)
    repeat (16) press(KEY_PLUS);
    `CHK(disp_value_o, ADDR_MAX)
    auto_step(2'h2, ADDR_MAX);
    tick(4);
    `CHK(disp_menu_o, 1'b0)
  endtask

  // Menu source in use: idle and address switches have no say
  task automatic t_src();
    dip_i <= 8'h3A;
    tick(5);
    `CHK(bus_addr_o, ADDR_MAX)
    `CHK(baud_fast_o, 1'b0)
    `CHK(idle_100ms_o, 1'b0)
    `CHK(rx_circle_o, CIRCLE_MAX)
    wb(1'b0, REG_CONFIG, 32'h0000_0000);
    `CHK(rd[31:12], {TX_OBJ, TX_GID, TX_CIRCLE, RX_OBJ, RX_GID})
    `CHK(rd[11:0], {CIRCLE_MAX, 1'b0, 1'b0, ADDR_MAX})
  endtask

  task automatic t_run();
    int i;
    send <= 1'b1;
    for (i = 0; i < 20; i++) begin
      @(posedge clk_i);
      if (disp_wait_o === 1'b0) break;
    end
    `CHK(disp_wait_o, 1'b0)
    chord(1'b0);
  endtask

  task automatic t_image();
    for (int i = 0; i < 12; i++) begin
      key_i <= KEYS;
      override_code_bits_i <= OVR_TBL[i];
      keyswitch_i <= i[0];
      disp_ack_i <= ~i[0];
      tick(5);
      `CHK(image_o, {~i[0], i[0], 1'b0, OVR_TBL[i], KEYS[19:16], 4'h0, KEYS[15:0], 16'h0000})
      wb(1'b0, REG_STATUS, 32'h0000_0000);
      `CHK(rd[7:4], 4'(i + 1))
    end
    // Last pass left keyswitch on and acknowledge off
    wb(1'b0, REG_IMG_LO, 32'h0000_0000);
    `CHK(rd, {KEYS[15:0], 16'h0000})
    wb(1'b0, REG_IMG_HI, 32'h0000_0000);
    `CHK(rd, {16'h0000, 1'b0, 1'b1, 1'b0, OVR_TBL[11], KEYS[19:16], 4'h0})
    key_i <= 20'h0_0000;
  endtask

  task automatic t_flash();
    flash_valid_i <= 1'b1;
    flash_circle_i <= 5'h05;
    flash_addr_i <= 5'h07;
    do_reset();
    `CHK(rx_circle_o, 5'h05)
    `CHK(bus_addr_o, 5'h07)
    `CHK(baud_fast_o, 1'b0)
    flash_circle_i <= 5'h11;
    do_reset();
    `CHK(rx_circle_o, CIRCLE_DEF)
    `CHK(bus_addr_o, ADDR_DEF)
  endtask

  // ****
  // Main sequence
  // ****
  initial begin
    {wb_cyc_i, wb_stb_i, wb_we_i, keyswitch_i, disp_ack_i} = 5'h00;
    {flash_valid_i, flash_baud_i} = 2'h0;
    {wb_adr_i, wb_sel_i, wb_dat_i} = 44'h0;
    {key_i, override_code_bits_i, flash_circle_i, flash_addr_i} = 35'h0;
    dip_i = 8'h3A;
    do_reset();
    t_reset();
    t_switches();
    t_alt();
    t_menu();
    t_src();
    t_run();
    t_image();
    t_flash();
    close_out();
  end
endmodule // test_hou_setup
